// [eprom_model.sv]
`timescale 1ns/1ps
`default_nettype none
module eprom_model #(
  parameter int unsigned ADDR_W = 3,
  parameter int unsigned PULSE_LO = 45,
  parameter int unsigned PULSE_HI = 55,
  // identification bytes: arbitrary values
  parameter logic [7:0] MAKER_CODE = 8'h5A,
  parameter logic [7:0] DEVICE_CODE = 8'hC3
) (
  input wire logic sys_clk_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic chip_sel_n_i,
  input wire logic out_en_n_i,
  input wire logic [7:0] host_data_i,
  input wire logic host_oe_n_i,
  input wire logic vcc_high_i,
  input wire logic vpp_high_i,
  input wire logic hv_line_i,
  output logic [7:0] pin_data_o,
  output logic [7:0] viol_o
);
  logic [7:0] mem [1<<ADDR_W];
  int need [1<<ADDR_W];
  int pulses [1<<ADDR_W];
  int drift_addr = -1;
  int pw = 0;
  int oe_cnt = 0;
  int flt_cnt = 0;
  logic [7:0] last = 8'h00;
  logic [7:0] held = 8'h00;
  logic [7:0] dev_val;
  logic [7:0] p_data;
  logic [ADDR_W-1:0] p_addr;
  logic vpp_prev = 1'b0;
  logic drive_now;

  task automatic erase();
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      mem[i] = 8'hFF;
      need[i] = 1;
      pulses[i] = 0;
    end
    drift_addr = -1;
    viol_o = 8'h00;
  endtask

  always @* begin
    if (hv_line_i)
      dev_val = addr_i[0] ? DEVICE_CODE : MAKER_CODE;
    else if (!vcc_high_i && int'(addr_i) == drift_addr)
      dev_val = mem[addr_i] ^ 8'h01;
    else
      dev_val = mem[addr_i];
    // output is only valid 150 ns after output enable falls
    drive_now = !out_en_n_i && (!chip_sel_n_i || vpp_high_i) && oe_cnt >= 15;
    if (!host_oe_n_i)
      pin_data_o = host_data_i;
    else if (drive_now)
      pin_data_o = dev_val;
    else if (flt_cnt > 0)
      pin_data_o = held;
    else
      pin_data_o = ~last; // no pull on the bus: churn so no stale value
  end

  always @(posedge sys_clk_i) begin
    last <= pin_data_o;
    oe_cnt <= out_en_n_i ? 0 : oe_cnt + 1;
    if (drive_now)
      held <= dev_val;
    flt_cnt <= drive_now ? 12 : (flt_cnt > 0 ? flt_cnt - 1 : 0);
    vpp_prev <= vpp_high_i;
    if (!host_oe_n_i && (drive_now || flt_cnt > 0))
      viol_o += 8'h01;
    if (vpp_high_i && !vcc_high_i)
      viol_o += 8'h01;
    if (vpp_high_i && !vpp_prev && addr_i != '0)
      viol_o += 8'h01;
    if (hv_line_i && !chip_sel_n_i && !out_en_n_i && (addr_i >> 1) != '0)
      viol_o += 8'h01;
    if (!chip_sel_n_i && vpp_high_i) begin
      if (pw == 0) begin
        p_addr = addr_i;
        p_data = host_data_i;
      end
      if (addr_i != p_addr || host_data_i != p_data || !out_en_n_i)
        viol_o += 8'h01;
      if (host_oe_n_i)
        viol_o += 8'h01;
      pw++;
    end else if (pw > 0) begin
      if (pw < PULSE_LO || pw > PULSE_HI)
        viol_o += 8'h01;
      pulses[addr_i]++;
      if (pulses[addr_i] >= need[addr_i])
        mem[addr_i] <= mem[addr_i] & host_data_i;
      pw = 0;
    end
  end
endmodule
`default_nettype wire

// [eprom_prog_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// Operation
// - program pulse on chip select lasts 95 to 105 us, nominal 100
// - select address zero, raise core supply, then programming supply
// - first pass gives each address one pulse, no verify
// - then verify and reprogram each address separately against source
// - a failing byte gets up to 10 single pulses, verified each time
// - still failing after 10 retries: part failed, programming stops
// - a verified byte moves on to the next address until all checked
// - drop both supplies to nominal, read all bytes, final pass/fail (code stops the read at the first mismatch)
// - sample 150 ns after output enable, wait 130 ns before driving
// - core supply up first and down last relative to programming supply
// - id mode: chip select, output enable low, other lines low, hv line up
module eprom_prog_ctrl
  import eprom_prog_pkg::*;
#(
  parameter int unsigned ADDR_W = 15,
  parameter int unsigned PULSE_CYC = PULSE_NOM_CYC,
  parameter int unsigned PULSE_LO_CYC = PULSE_MIN_CYC,
  parameter int unsigned PULSE_HI_CYC = PULSE_MAX_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic start_prog_i,
  input wire logic start_id_i,
  output logic fetch_o,
  output logic [ADDR_W-1:0] fetch_addr_o,
  input wire logic src_valid_i,
  output logic src_ready_o,
  input wire logic [7:0] src_data_i,
  output logic busy_o,
  output logic done_o,
  output logic pass_o,
  output logic fail_o,
  output logic [ADDR_W-1:0] fail_addr_o,
  output logic [7:0] maker_code_o,
  output logic [7:0] device_code_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic chip_sel_n_o,
  output logic out_en_n_o,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  output logic vcc_high_o,
  output logic vpp_high_o,
  output logic id_mode_high_voltage_line_o
);
  state_t state_q, state_d;
  pass_t pass_q, pass_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [3:0] retry_q, retry_d;
  logic [7:0] want_q, want_d, maker_q, maker_d, dev_q, dev_d;
  logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, doe_n_q, doe_n_d;
  logic vcc_q, vcc_d, vpp_q, vpp_d, hv_q, hv_d;
  logic match_q, match_d, failed_q, failed_d, ok_q, ok_d;
  logic fetch_q, fetch_d, busy_q, busy_d, done_q, done_d;
  logic [7:0] sync1_q, sync2_q;
  logic buf_valid, buf_ready;
  logic [7:0] buf_data;
  logic tdone, last;

  skid_buffer #(.WIDTH(8), .DEPTH(2)) u_buf (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .in_valid_i(src_valid_i),
    .in_ready_o(src_ready_o),
    .in_data_i(src_data_i),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_ready),
    .out_data_o(buf_data)
  );

  assign tdone = (tmr_q == '0);
  assign last = (addr_q == {ADDR_W{1'b1}});
  assign buf_ready = (state_q == ST_WAIT_DATA);

  always_comb begin
    state_d = state_q;
    pass_d = pass_q;
    tmr_d = tdone ? tmr_q : tmr_q - 1'b1;
    addr_d = addr_q;
    retry_d = retry_q;
    want_d = want_q;
    maker_d = maker_q;
    dev_d = dev_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    doe_n_d = doe_n_q;
    vcc_d = vcc_q;
    vpp_d = vpp_q;
    hv_d = hv_q;
    match_d = match_q;
    failed_d = failed_q;
    fetch_d = 1'b0;
    done_d = 1'b0;
    ok_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        addr_d = '0;
        retry_d = RETRY_RST;
        if (start_prog_i) begin
          failed_d = 1'b0;
          pass_d = PASS_FIRST;
          vcc_d = 1'b1;
          tmr_d = tload(SETUP_CYC);
          state_d = ST_VCC_UP;
        end else if (start_id_i) begin
          failed_d = 1'b0;
          pass_d = PASS_ID;
          hv_d = 1'b1;
          tmr_d = tload(SETUP_CYC);
          state_d = ST_ID_SETUP;
        end
      end
      ST_VCC_UP: if (tdone) begin
        vpp_d = 1'b1;
        tmr_d = tload(SETUP_CYC);
        state_d = ST_VPP_UP;
      end
      ST_VPP_UP: if (tdone) begin
        state_d = ST_FETCH;
      end
      ST_FETCH: begin
        fetch_d = 1'b1;
        state_d = ST_WAIT_DATA;
      end
      ST_WAIT_DATA: if (buf_valid) begin
        want_d = buf_data;
        if (pass_q == PASS_FIRST) begin
          doe_n_d = 1'b0;
          tmr_d = tload(SETUP_CYC);
          state_d = ST_SETUP;
        end else begin
          // reading only happens in the later passes
          oe_n_d = 1'b0;
          ce_n_d = (pass_q != PASS_FINAL);
          tmr_d = tload(READ_CYC);
          state_d = ST_READ;
        end
      end
      ST_SETUP: if (tdone) begin
        ce_n_d = 1'b0;
        tmr_d = tload(PULSE_CYC);
        state_d = ST_PULSE;
      end
      ST_PULSE: if (tdone) begin
        ce_n_d = 1'b1;
        tmr_d = tload(SETUP_CYC);
        state_d = ST_HOLD;
      end
      ST_HOLD: if (tdone) begin
        doe_n_d = 1'b1;
        if (pass_q == PASS_FIRST) begin
          // one pulse per address, then the verify pass from zero
          addr_d = last ? '0 : addr_q + 1'b1;
          pass_d = last ? PASS_VERIFY : PASS_FIRST;
          state_d = ST_FETCH;
        end else begin
          oe_n_d = 1'b0;
          tmr_d = tload(READ_CYC);
          state_d = ST_READ;
        end
      end
      ST_READ: if (tdone) begin
        match_d = (sync2_q == want_q);
        oe_n_d = 1'b1;
        ce_n_d = 1'b1;
        tmr_d = tload(FLOAT_CYC);
        state_d = ST_FLOAT;
      end
      ST_FLOAT: if (tdone) begin
        if (pass_q == PASS_VERIFY) begin
          if (match_q) begin
            retry_d = RETRY_RST;
            addr_d = addr_q + 1'b1;
            state_d = last ? ST_VPP_DOWN : ST_FETCH;
            vpp_d = !last;
            tmr_d = tload(SETUP_CYC);
          end else if (retry_q == RETRY_MAX) begin
            failed_d = 1'b1;
            vpp_d = 1'b0;
            tmr_d = tload(SETUP_CYC);
            state_d = ST_VPP_DOWN;
          end else begin
            retry_d = retry_q + 1'b1;
            doe_n_d = 1'b0; // float time already waited
            tmr_d = tload(SETUP_CYC);
            state_d = ST_SETUP;
          end
        end else begin
          // final compare stops at the first mismatch
          failed_d = !match_q;
          addr_d = (match_q && !last) ? addr_q + 1'b1 : addr_q;
          state_d = (match_q && !last) ? ST_FETCH : ST_DONE;
        end
      end
      ST_VPP_DOWN: if (tdone) begin
        vcc_d = 1'b0;
        tmr_d = tload(SETUP_CYC);
        state_d = ST_VCC_DOWN;
      end
      ST_VCC_DOWN: if (tdone) begin
        pass_d = PASS_FINAL;
        state_d = failed_q ? ST_DONE : ST_FETCH;
      end
      ST_ID_SETUP: if (tdone) begin
        ce_n_d = 1'b0;
        oe_n_d = 1'b0;
        tmr_d = tload(READ_CYC);
        state_d = ST_ID_READ;
      end
      ST_ID_READ: if (tdone) begin
        if (!addr_q[0]) begin
          maker_d = sync2_q;
          addr_d = {{(ADDR_W-1){1'b0}}, 1'b1};
          tmr_d = tload(READ_CYC);
        end else begin
          dev_d = sync2_q;
          ce_n_d = 1'b1;
          oe_n_d = 1'b1;
          hv_d = 1'b0;
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        done_d = 1'b1;
        ok_d = !failed_q;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    busy_d = (state_d != ST_IDLE);
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      pass_q <= PASS_FIRST;
      tmr_q <= '0;
      addr_q <= '0;
      retry_q <= RETRY_RST;
      want_q <= DATA_RST;
      maker_q <= DATA_RST;
      dev_q <= DATA_RST;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      doe_n_q <= 1'b1;
      vcc_q <= 1'b0;
      vpp_q <= 1'b0;
      hv_q <= 1'b0;
      match_q <= 1'b0;
      failed_q <= 1'b0;
      ok_q <= 1'b0;
      fetch_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      sync1_q <= DATA_RST;
      sync2_q <= DATA_RST;
    end else if (clk_en_i) begin
      state_q <= state_d;
      pass_q <= pass_d;
      tmr_q <= tmr_d;
      addr_q <= addr_d;
      retry_q <= retry_d;
      want_q <= want_d;
      maker_q <= maker_d;
      dev_q <= dev_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      doe_n_q <= doe_n_d;
      vcc_q <= vcc_d;
      vpp_q <= vpp_d;
      hv_q <= hv_d;
      match_q <= match_d;
      failed_q <= failed_d;
      ok_q <= ok_d;
      fetch_q <= fetch_d;
      busy_q <= busy_d;
      done_q <= done_d;
      sync1_q <= data_i;
      sync2_q <= sync1_q;
    end
  end

  assign fetch_o = fetch_q;
  assign fetch_addr_o = addr_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign pass_o = ok_q;
  assign fail_o = failed_q;
  assign fail_addr_o = addr_q;
  assign maker_code_o = maker_q;
  assign device_code_o = dev_q;
  assign addr_o = addr_q;
  assign chip_sel_n_o = ce_n_q;
  assign out_en_n_o = oe_n_q;
  assign data_o = want_q;
  assign data_oe_n_o = doe_n_q;
  assign vcc_high_o = vcc_q;
  assign vpp_high_o = vpp_q;
  assign id_mode_high_voltage_line_o = hv_q;

  // helper counters for the timing checks below
  logic [TMR_W-1:0] ce_low_cnt_q, oe_low_cnt_q;
  logic [7:0] oe_high_cnt_q;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ce_low_cnt_q <= '0;
      oe_low_cnt_q <= '0;
      oe_high_cnt_q <= 8'hFF;
    end else if (clk_en_i) begin
      ce_low_cnt_q <= ce_n_q ? '0 : ce_low_cnt_q + 1'b1;
      oe_low_cnt_q <= oe_n_q ? '0 : oe_low_cnt_q + 1'b1;
      oe_high_cnt_q <= !oe_n_q ? 8'h00 :
        (oe_high_cnt_q == 8'hFF) ? oe_high_cnt_q : oe_high_cnt_q + 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_pulse_start;
    $fell(ce_n_q) && vpp_q;
  endsequence
  sequence s_pulse_quiet;
    (oe_n_q && !doe_n_q && $stable(addr_q) && $stable(want_q)) [*8];
  endsequence

  a_pulse_width: assert property (
    $rose(ce_n_q) && vpp_q |->
      ce_low_cnt_q >= TMR_W'(PULSE_LO_CYC) &&
      ce_low_cnt_q <= TMR_W'(PULSE_HI_CYC))
    else $error("program pulse width out of range");
  a_supply_raise: assert property (
    $rose(vpp_q) |-> addr_q == '0 && vcc_q && $past(vcc_q))
    else $error("programming supply raised out of order");
  a_first_no_read: assert property (
    pass_q == PASS_FIRST && vpp_q |-> oe_n_q)
    else $error("read during first programming pass");
  a_retry_bound: assert property (
    retry_q <= RETRY_MAX)
    else $error("retry count above limit");
  a_fail_stop: assert property (
    clk_en_i && state_q == ST_FLOAT && tdone && pass_q == PASS_VERIFY &&
    !match_q && retry_q == RETRY_MAX |=> failed_q && !vpp_q)
    else $error("failed byte did not stop programming");
  a_next_addr: assert property (
    clk_en_i && state_q == ST_FLOAT && tdone && pass_q == PASS_VERIFY &&
    match_q && !last |=> addr_q == $past(addr_q) + 1'b1 &&
      state_q == ST_FETCH)
    else $error("verified byte did not advance address");
  a_final_nominal: assert property (
    pass_q == PASS_FINAL && !oe_n_q |-> !vpp_q && !vcc_q)
    else $error("final read not at nominal supply");
  a_sample_wait: assert property (
    state_q == ST_READ && tdone |->
      oe_low_cnt_q >= TMR_W'(OE_WAIT_CYC + SYNC_STAGES))
    else $error("data sampled too early after output enable");
  a_float_gap: assert property (
    $fell(doe_n_q) |-> oe_high_cnt_q >= 8'(FLOAT_CYC))
    else $error("data driven before device output floated");
  a_supply_order: assert property (
    vpp_q |-> vcc_q)
    else $error("programming supply without core supply");
  a_id_address: assert property (
    hv_q && !ce_n_q |-> !oe_n_q && addr_q[ADDR_W-1:1] == '0 && !vpp_q)
    else $error("identification mode pins wrong");
  a_pulse_quiet: assert property (
    s_pulse_start |-> s_pulse_quiet)
    else $error("pins moved during program pulse");
endmodule
`default_nettype wire

// [eprom_prog_pkg.sv]
`default_nettype none
package eprom_prog_pkg;

  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CLK_PERIOD_NS = 10;

  // programming pulse, microseconds
  localparam int unsigned PULSE_NOM_US = 100;
  localparam int unsigned PULSE_MIN_US = 95;
  localparam int unsigned PULSE_MAX_US = 105;
  localparam int unsigned PULSE_NOM_CYC = PULSE_NOM_US * CLK_MHZ;
  localparam int unsigned PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ;
  localparam int unsigned PULSE_MAX_CYC = PULSE_MAX_US * CLK_MHZ;

  // address, data, supply and output enable setup / hold
  localparam int unsigned SETUP_US = 2;
  localparam int unsigned SETUP_CYC = SETUP_US * CLK_MHZ;

  // data valid after output enable, and output float after release
  localparam int unsigned OE_VALID_NS = 150;
  localparam int unsigned FLOAT_NS = 130;
  localparam int unsigned OE_WAIT_CYC =
    (OE_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FLOAT_CYC =
    (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned SYNC_STAGES = 2;
  // one spare cycle so the sampled word has settled through the sync
  localparam int unsigned READ_CYC = OE_WAIT_CYC + SYNC_STAGES + 1;

  localparam int unsigned TMR_W = 16;
  localparam logic [3:0] RETRY_MAX = 4'hA;
  localparam logic [3:0] RETRY_RST = 4'h0;
  localparam logic [7:0] DATA_RST = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_VCC_UP = 4'h1,
    ST_VPP_UP = 4'h2,
    ST_FETCH = 4'h3,
    ST_WAIT_DATA = 4'h4,
    ST_SETUP = 4'h5,
    ST_PULSE = 4'h6,
    ST_HOLD = 4'h7,
    ST_READ = 4'h8,
    ST_FLOAT = 4'h9,
    ST_VPP_DOWN = 4'hA,
    ST_VCC_DOWN = 4'hB,
    ST_ID_SETUP = 4'hC,
    ST_ID_READ = 4'hD,
    ST_DONE = 4'hE
  } state_t;

  typedef enum logic [1:0] {
    PASS_FIRST = 2'h0,
    PASS_VERIFY = 2'h1,
    PASS_FINAL = 2'h2,
    PASS_ID = 2'h3
  } pass_t;

  function automatic logic [TMR_W-1:0] tload(input int unsigned cyc);
    tload = TMR_W'(cyc - 1);
  endfunction

endpackage
`default_nettype wire

// [skid_buffer.sv]
`timescale 1ns/1ps
`default_nettype none
module skid_buffer #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d;
  logic push, pop;

  // ready is registered so the top's source-side output comes from a flop
  assign in_ready_o = rdy_q;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];

  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data_i;
      wr_d = (wr_q == LAST) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == LAST) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    rdy_d = (cnt_d != FULL);
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (clk_en_i) begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      mem_q <= mem_d;
    end
  end
endmodule
`default_nettype wire

// [tb_eprom_prog_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
  failures++; $display("wrong value at %0t: got %0h expected %0h", \
  $time, (got), (exp)); end end
module tb_eprom_prog_ctrl;
  localparam int unsigned AW = 3;
  // identification bytes: arbitrary values
  localparam logic [7:0] MAKER = 8'h5A;
  localparam logic [7:0] DEVICE = 8'hC3;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic clk_en = 1'b1;
  logic start_prog_i = 1'b0;
  logic start_id_i = 1'b0;
  logic src_valid_i = 1'b0;
  logic [7:0] src_data_i = 8'h00;
  logic fetch_o, src_ready_o, busy_o, done_o, pass_o, fail_o;
  logic chip_sel_n_o, out_en_n_o, data_oe_n_o, vcc_high_o, vpp_high_o, hv_o;
  logic [AW-1:0] fetch_addr_o, fail_addr_o, addr_o;
  logic [7:0] maker_code_o, device_code_o, data_o, pin_data, viol;
  logic r_done, r_pass, r_fail;
  logic [AW-1:0] r_addr;
  logic [AW-1:0] fq[$];
  int skip = 0;
  int lag = 0;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  eprom_prog_ctrl #(.ADDR_W(AW), .PULSE_CYC(50), .PULSE_LO_CYC(45),
    .PULSE_HI_CYC(55)) eprom_prog_ctrl_inst (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en),
    .start_prog_i(start_prog_i), .start_id_i(start_id_i),
    .fetch_o(fetch_o), .fetch_addr_o(fetch_addr_o),
    .src_valid_i(src_valid_i), .src_ready_o(src_ready_o),
    .src_data_i(src_data_i), .busy_o(busy_o), .done_o(done_o),
    .pass_o(pass_o), .fail_o(fail_o), .fail_addr_o(fail_addr_o),
    .maker_code_o(maker_code_o), .device_code_o(device_code_o),
    .addr_o(addr_o), .chip_sel_n_o(chip_sel_n_o), .out_en_n_o(out_en_n_o),
    .data_i(pin_data), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
    .vcc_high_o(vcc_high_o), .vpp_high_o(vpp_high_o),
    .id_mode_high_voltage_line_o(hv_o));

  eprom_model #(.ADDR_W(AW), .PULSE_LO(45), .PULSE_HI(55),
    .MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) eprom_model_inst (
    .sys_clk_i(sys_clk_i), .addr_i(addr_o), .chip_sel_n_i(chip_sel_n_o),
    .out_en_n_i(out_en_n_o), .host_data_i(data_o),
    .host_oe_n_i(data_oe_n_o), .vcc_high_i(vcc_high_o),
    .vpp_high_i(vpp_high_o), .hv_line_i(hv_o), .pin_data_o(pin_data),
    .viol_o(viol));

  function automatic logic [7:0] src_byte(input logic [AW-1:0] a);
    return 8'h42 + 8'(a) * 8'h1D;
  endfunction

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      close_out();
    end
  end

  // fetches already answered by a pre-push are skipped
  always @(posedge sys_clk_i) begin
    #1;
    if (fetch_o === 1'b1) begin
      if (skip > 0)
        skip--;
      else
        fq.push_back(fetch_addr_o);
    end
  end

  initial begin : source
    logic [AW-1:0] a;
    forever begin
      @(posedge sys_clk_i);
      #1;
      if (fq.size() > 0) begin
        a = fq.pop_front();
        repeat (lag) begin
          @(posedge sys_clk_i);
          #1;
        end
        src_valid_i = 1'b1;
        src_data_i = src_byte(a);
        while (src_ready_o !== 1'b1) begin
          @(posedge sys_clk_i);
          #1;
        end
        @(posedge sys_clk_i);
        #1;
        src_valid_i = 1'b0;
        src_data_i = ~src_data_i;
      end
    end
  end

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic run(input bit prog);
    int n;
    n = 0;
    r_done = 1'b0;
    if (prog)
      start_prog_i = 1'b1;
    else
      start_id_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    start_prog_i = 1'b0;
    start_id_i = 1'b0;
    while (!r_done && n < 30000) begin
      @(posedge sys_clk_i);
      #1;
      n++;
      if (prog && n == 20)
        `CHK(src_ready_o, (skip > 0) ? 1'b0 : 1'b1)
      if (done_o === 1'b1) begin
        r_done = 1'b1;
        r_pass = pass_o;
        r_fail = fail_o;
        r_addr = fail_addr_o;
      end
    end
    `CHK(r_done, 1'b1)
    `CHK(vpp_high_o, 1'b0)
    `CHK(vcc_high_o, 1'b0)
  endtask

  task automatic t_id();
    eprom_model_inst.erase();
    run(1'b0);
    `CHK(maker_code_o, MAKER)
    `CHK(device_code_o, DEVICE)
    `CHK(viol, 8'h00)
    $display("test id_read done");
  endtask

  // id run frozen for 300 cycles mid setup: nothing may move meanwhile
  task automatic t_freeze();
    int n;
    n = 0;
    eprom_model_inst.erase();
    start_id_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    start_id_i = 1'b0;
    repeat (100) @(posedge sys_clk_i);
    #1;
    clk_en = 1'b0;
    repeat (300) @(posedge sys_clk_i);
    #1;
    `CHK(chip_sel_n_o, 1'b1)
    `CHK(hv_o, 1'b1)
    `CHK(busy_o, 1'b1)
    clk_en = 1'b1;
    while (done_o !== 1'b1 && n < 1000) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    `CHK(n, 137)
    `CHK(maker_code_o, MAKER)
    `CHK(device_code_o, DEVICE)
    `CHK(viol, 8'h00)
    $display("test clock_freeze done");
  endtask

  task automatic t_clean();
    eprom_model_inst.erase();
    for (int i = 0; i < 3; i++)
      fq.push_back(AW'(i));
    skip = 3;
    run(1'b1);
    `CHK(r_pass, 1'b1)
    `CHK(r_fail, 1'b0)
    for (int a = 0; a < 8; a++) begin
      `CHK(eprom_model_inst.pulses[a], 1)
      `CHK(eprom_model_inst.mem[a], src_byte(AW'(a)))
    end
    `CHK(viol, 8'h00)
    $display("test clean_program done");
  endtask

  task automatic t_retry();
    eprom_model_inst.erase();
    eprom_model_inst.need[3] = 4;
    lag = 20;
    run(1'b1);
    `CHK(r_pass, 1'b1)
    `CHK(eprom_model_inst.pulses[3], 4)
    `CHK(eprom_model_inst.pulses[4], 1)
    `CHK(eprom_model_inst.mem[3], src_byte(3'h3))
    `CHK(viol, 8'h00)
    $display("test retry_program done");
  endtask

  task automatic t_stuck();
    eprom_model_inst.erase();
    eprom_model_inst.need[5] = 99;
    lag = 0;
    run(1'b1);
    `CHK(r_fail, 1'b1)
    `CHK(r_pass, 1'b0)
    `CHK(r_addr, 3'h5)
    `CHK(eprom_model_inst.pulses[5], 11)
    `CHK(eprom_model_inst.pulses[6], 1)
    `CHK(viol, 8'h00)
    $display("test stuck_byte done");
  endtask

  task automatic t_drift();
    eprom_model_inst.erase();
    eprom_model_inst.drift_addr = 2;
    run(1'b1);
    `CHK(r_fail, 1'b1)
    `CHK(r_pass, 1'b0)
    `CHK(r_addr, 3'h2)
    `CHK(eprom_model_inst.pulses[2], 1)
    $display("test final_compare done");
  endtask

  initial begin
    repeat (5) @(posedge sys_clk_i);
    #1;
    reset_i = 1'b0;
    t_id();
    t_freeze();
    t_clean();
    t_retry();
    t_stuck();
    t_drift();
    close_out();
  end
endmodule
`default_nettype wire
